// File: design/emx_exec.v
// execution unit for swap, skip, table read and xor instructions
//
// Our own choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "emx_map.vh"
module emx_exec #(
  parameter AW = 8,
  parameter PW = 16,
  parameter PAW = 16
) (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [3:0] sel_i,
  input wire [4:0] adr_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output wire ack_o,
  output reg [AW-1:0] mem_addr_o,
  output reg mem_rd_o,
  input wire [7:0] mem_rdata_i,
  output reg mem_we_o,
  output reg [7:0] mem_wdata_o,
  output reg [PAW-1:0] prog_addr_o,
  output reg prog_rd_o,
  input wire [PW-1:0] prog_data_i,
  output reg busy_o,
  output reg skip_o,
  output reg dummy_o,
  output reg zero_o
);
  // ------------------------------------------------------------
  // states
  // ------------------------------------------------------------
  localparam [4:0] S_IDLE = 5'b0_0001;
  localparam [4:0] S_FETCH = 5'b0_0010;
  localparam [4:0] S_EXEC = 5'b0_0100;
  localparam [4:0] S_DUMMY = 5'b0_1000;
  localparam [4:0] S_DONE = 5'b1_0000;

  reg [4:0] state_ff, nxt_state;
  reg [3:0] op_ff;
  reg [2:0] bit_ff;
  reg [7:0] acc_ff, tpl_ff, tph_ff, tbh_ff;
  reg [7:0] cycles_ff;
  reg [1:0] cnt_ff;
  wire wr_stb, rd_stb;

  // ------------------------------------------------------------
  // wishbone front end
  // ------------------------------------------------------------
  emx_wb_slave u_wb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .ack_o(ack_o),
    .wr_stb_o(wr_stb),
    .rd_stb_o(rd_stb)
  );

  // ------------------------------------------------------------
  // operand decode
  // ------------------------------------------------------------
  wire is_tbl = (op_ff == `EMX_OP_TRD_PAGE) || (op_ff == `EMX_OP_TRD_LAST) ||
                (op_ff == `EMX_OP_ITRD_PAGE) || (op_ff == `EMX_OP_ITRD_LAST);
  wire is_last = (op_ff == `EMX_OP_TRD_LAST) || (op_ff == `EMX_OP_ITRD_LAST);
  wire is_inc = (op_ff == `EMX_OP_ITRD_PAGE) || (op_ff == `EMX_OP_ITRD_LAST);
  wire [7:0] swapped = {mem_rdata_i[3:0], mem_rdata_i[7:4]};
  wire [7:0] xor_val = acc_ff ^ mem_rdata_i;
  wire byte_zero = (mem_rdata_i == 8'h00);
  wire bit_zero = ~mem_rdata_i[bit_ff];
  wire reg_wr = wr_stb & we_i & sel_i[0] & state_ff[0];
  wire cmd_wr = reg_wr & (adr_i == `EMX_REG_CMD);
  // ------------------------------------------------------------
  // program address: last page has all upper bits set
  // ------------------------------------------------------------
  wire [7:0] tpl_eff = is_inc ? tpl_ff + 8'h01 : tpl_ff;
  wire [PAW-9:0] last_hi = {(PAW-8){1'b1}};
  wire [PAW-9:0] page_hi = tph_ff[PAW-9:0];

  // ------------------------------------------------------------
  // skip decision
  // ------------------------------------------------------------
  // only the three skip opcodes can ever take the dummy path
  reg take_skip;
  always @* begin
    take_skip = 1'b0;
    case (op_ff)
      `EMX_OP_SZ_MEM: take_skip = byte_zero;
      `EMX_OP_SZ_ACC: take_skip = byte_zero;
      `EMX_OP_SZ_BIT: take_skip = bit_zero;
      default: take_skip = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      S_IDLE: if (cmd_wr) nxt_state = S_FETCH;
      S_FETCH: nxt_state = S_EXEC;
      S_EXEC: nxt_state = take_skip ? S_DUMMY : S_DONE;
      S_DUMMY: nxt_state = S_DONE;
      S_DONE: nxt_state = S_IDLE;
      default: nxt_state = S_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // sequencer state and cycle counter
  // ------------------------------------------------------------
  // the counter reports the real length, so a lost dummy cycle shows up in status
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= S_IDLE;
      cnt_ff <= 2'h0;
    end else if (ce_i) begin
      state_ff <= nxt_state;
      if (cmd_wr) begin
        cnt_ff <= 2'h0;
      end else if (!state_ff[0]) begin
        cnt_ff <= cnt_ff + 2'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // latched command fields
  // ------------------------------------------------------------
  // captured once so bus traffic cannot disturb a running instruction
  always @(posedge clk_i) begin
    if (rst_i) begin
      op_ff <= 4'h0;
      bit_ff <= 3'h0;
      mem_addr_o <= {AW{1'b0}};
    end else if (ce_i) begin
      if (cmd_wr) begin
        op_ff <= dat_i[`EMX_CMD_OP_LSB+3:`EMX_CMD_OP_LSB];
        bit_ff <= dat_i[`EMX_CMD_BIT_LSB+2:`EMX_CMD_BIT_LSB];
        mem_addr_o <= dat_i[`EMX_CMD_ADDR_LSB+AW-1:`EMX_CMD_ADDR_LSB];
      end
    end
  end

  // ------------------------------------------------------------
  // accumulator, table pointers and table high latch
  // ------------------------------------------------------------
  // bus writes only land while idle so an instruction sees stable operands
  always @(posedge clk_i) begin
    if (rst_i) begin
      acc_ff <= `EMX_ACC_RST;
      tpl_ff <= `EMX_TBL_RST;
      tph_ff <= `EMX_TBL_RST;
      tbh_ff <= `EMX_TBL_RST;
    end else if (ce_i) begin
      if (reg_wr) begin
        case (adr_i)
          `EMX_REG_ACC: acc_ff <= dat_i[7:0];
          `EMX_REG_TPL: tpl_ff <= dat_i[7:0];
          `EMX_REG_TPH: tph_ff <= dat_i[7:0];
          default: ;
        endcase
      end
      if (state_ff == S_FETCH && is_tbl) begin
        tpl_ff <= tpl_eff;
      end
      if (state_ff == S_EXEC) begin
        case (op_ff)
          `EMX_OP_SWAP_ACC: acc_ff <= swapped;
          `EMX_OP_SZ_ACC: acc_ff <= mem_rdata_i;
          `EMX_OP_XOR_ACC: acc_ff <= xor_val;
          `EMX_OP_TRD_PAGE, `EMX_OP_TRD_LAST, `EMX_OP_ITRD_PAGE, `EMX_OP_ITRD_LAST: begin
            tbh_ff <= prog_data_i[PW-1:8];
          end
          default: ;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // data and program memory strobes
  // ------------------------------------------------------------
  // both memories must answer in the cycle the read strobe is high
  always @(posedge clk_i) begin
    if (rst_i) begin
      mem_rd_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_wdata_o <= 8'h00;
      prog_addr_o <= {PAW{1'b0}};
      prog_rd_o <= 1'b0;
    end else if (ce_i) begin
      mem_rd_o <= 1'b0;
      mem_we_o <= 1'b0;
      prog_rd_o <= 1'b0;
      if (state_ff == S_FETCH) begin
        if (is_tbl) begin
          prog_addr_o <= {is_last ? last_hi : page_hi, tpl_eff};
          prog_rd_o <= 1'b1;
        end else begin
          mem_rd_o <= 1'b1;
        end
      end
      if (state_ff == S_EXEC) begin
        case (op_ff)
          `EMX_OP_SWAP_MEM: begin
            mem_wdata_o <= swapped;
            mem_we_o <= 1'b1;
          end
          `EMX_OP_SZ_MEM: begin
            mem_wdata_o <= mem_rdata_i;
            mem_we_o <= 1'b1;
          end
          `EMX_OP_XOR_MEM: begin
            mem_wdata_o <= xor_val;
            mem_we_o <= 1'b1;
          end
          `EMX_OP_TRD_PAGE, `EMX_OP_TRD_LAST, `EMX_OP_ITRD_PAGE, `EMX_OP_ITRD_LAST: begin
            mem_wdata_o <= prog_data_i[7:0];
            mem_we_o <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // status flags
  // ------------------------------------------------------------
  // swaps, skips and table reads never reach the zero flag
  always @(posedge clk_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
      skip_o <= 1'b0;
      dummy_o <= 1'b0;
      zero_o <= 1'b0;
      cycles_ff <= 8'h00;
    end else if (ce_i) begin
      dummy_o <= 1'b0;
      case (state_ff)
        S_IDLE: begin
          if (cmd_wr) begin
            busy_o <= 1'b1;
            skip_o <= 1'b0;
          end
        end
        S_EXEC: begin
          skip_o <= take_skip;
          if (op_ff == `EMX_OP_XOR_ACC || op_ff == `EMX_OP_XOR_MEM) begin
            zero_o <= (xor_val == 8'h00);
          end
        end
        S_DUMMY: dummy_o <= 1'b1;
        S_DONE: begin
          busy_o <= 1'b0;
          cycles_ff <= {6'h00, cnt_ff};
        end
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // register read mux
  // ------------------------------------------------------------
  // status holds the length of the last finished instruction
  always @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (ce_i && rd_stb) begin
      case (adr_i)
        `EMX_REG_CMD: dat_o <= {16'h0000, mem_addr_o[7:0], 1'b0, bit_ff, op_ff};
        `EMX_REG_ACC: dat_o <= {24'h00_0000, acc_ff};
        `EMX_REG_TPL: dat_o <= {24'h00_0000, tpl_ff};
        `EMX_REG_TPH: dat_o <= {24'h00_0000, tph_ff};
        `EMX_REG_TBH: dat_o <= {24'h00_0000, tbh_ff};
        `EMX_REG_STAT: dat_o <= {16'h0000, cycles_ff, 5'h00, zero_o, skip_o, busy_o};
        default: dat_o <= 32'h0000_0000;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: design/emx_map.vh
// constants for the extended data-memory execution tail
`ifndef EMX_MAP_VH
`define EMX_MAP_VH
// ------------------------------------------------------------
// opcode select codes
// ------------------------------------------------------------
`define EMX_OP_SWAP_MEM 4'h1
`define EMX_OP_SWAP_ACC 4'h2
`define EMX_OP_SZ_MEM 4'h3
`define EMX_OP_SZ_ACC 4'h4
`define EMX_OP_SZ_BIT 4'h5
`define EMX_OP_TRD_PAGE 4'h6
`define EMX_OP_TRD_LAST 4'h7
`define EMX_OP_ITRD_PAGE 4'h8
`define EMX_OP_ITRD_LAST 4'h9
`define EMX_OP_XOR_ACC 4'hA
`define EMX_OP_XOR_MEM 4'hB
// ------------------------------------------------------------
// wishbone register offsets (byte addresses)
// ------------------------------------------------------------
`define EMX_REG_CMD 5'h00
`define EMX_REG_ACC 5'h04
`define EMX_REG_TPL 5'h08
`define EMX_REG_TPH 5'h0C
`define EMX_REG_TBH 5'h10
`define EMX_REG_STAT 5'h14
// ------------------------------------------------------------
// command register fields
// ------------------------------------------------------------
`define EMX_CMD_OP_LSB 0
`define EMX_CMD_BIT_LSB 4
`define EMX_CMD_ADDR_LSB 8
// ------------------------------------------------------------
// reset values and cycle counts
// ------------------------------------------------------------
`define EMX_ACC_RST 8'h00
`define EMX_TBL_RST 8'h00
`define EMX_CYC_SKIP 2'h3
`define EMX_CYC_NORM 2'h2
`endif

// File: design/emx_wb_slave.v
// wishbone classic single-cycle register slave front end
`timescale 1ns/1ps
`default_nettype none
module emx_wb_slave (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire cyc_i,
  input wire stb_i,
  output reg ack_o,
  output wire wr_stb_o,
  output wire rd_stb_o
);
  // ack one cycle after request, dropped the cycle after
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else if (ce_i) begin
      ack_o <= cyc_i & stb_i & ~ack_o;
    end
  end
  assign wr_stb_o = cyc_i & stb_i & ack_o;
  assign rd_stb_o = cyc_i & stb_i & ~ack_o;
endmodule
`default_nettype wire

// File: test/emx_exec_monitor.sv
// concurrent checks on the execution tail ports
`timescale 1ns/1ps
`default_nettype none
module emx_exec_monitor (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire ack_o,
  input wire mem_rd_o,
  input wire mem_we_o,
  input wire prog_rd_o,
  input wire busy_o,
  input wire skip_o,
  input wire dummy_o,
  input wire zero_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_start;
    $rose(busy_o);
  endsequence
  sequence s_fetch;
    mem_rd_o || prog_rd_o;
  endsequence
  sequence s_skip_taken;
    $rose(skip_o);
  endsequence
  a_skip_dummy: assert property (s_skip_taken |=> dummy_o)
    else $error("skip without dummy cycle");
  a_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acked");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held too long");
  a_fetch_first: assert property (s_start |=> s_fetch)
    else $error("no operand fetch");
  a_busy_bound: assert property (s_start |-> ##[2:6] !busy_o)
    else $error("instruction too long");
  a_idle_quiet: assert property (!busy_o |-> !(mem_rd_o || prog_rd_o))
    else $error("fetch while idle");
  a_write_busy: assert property (mem_we_o |-> busy_o)
    else $error("write while idle");
  a_dummy_skip: assert property (dummy_o |-> skip_o)
    else $error("dummy without skip");
  a_dummy_once: assert property (dummy_o |=> !dummy_o)
    else $error("dummy longer than one cycle");
  a_zero_idle: assert property (!busy_o && !$past(busy_o) |-> $stable(zero_o))
    else $error("zero flag moved while idle");
endmodule
bind emx_exec emx_exec_monitor u_emx_exec_monitor (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o,
  .mem_rd_o, .mem_we_o, .prog_rd_o, .busy_o, .skip_o, .dummy_o, .zero_o);
`default_nettype wire

// File: test/ext_mem_insn_exec_tail_tb.sv
// self-checking bench for the execution tail
`timescale 1ns/1ps
`default_nettype none
`include "emx_map.vh"
module ext_mem_insn_exec_tail_tb;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic [4:0] adr_i = 0;
  logic [31:0] dat_i = 0, rd;
  logic [15:0] lw;
  wire [7:0] mem_rdata_i;
  wire [15:0] prog_data_i;
  logic [7:0] dm [0:255];
  wire [31:0] dat_o;
  wire [7:0] mem_addr_o, mem_wdata_o;
  wire [15:0] prog_addr_o;
  wire ack_o, mem_rd_o, mem_we_o, prog_rd_o, busy_o, skip_o, dummy_o, zero_o;
  int failures = 0, total_checks = 0;
  always #2.5 clk_i = ~clk_i;
  emx_exec u_emx_exec (.clk_i, .rst_i, .ce_i(1'b1), .cyc_i, .stb_i, .we_i, .sel_i(4'h1),
    .adr_i, .dat_i, .dat_o, .ack_o, .mem_addr_o, .mem_rd_o, .mem_rdata_i, .mem_we_o,
    .mem_wdata_o, .prog_addr_o, .prog_rd_o, .prog_data_i, .busy_o, .skip_o, .dummy_o,
    .zero_o);
  // memories answer while their strobe is high and show the inverse otherwise
  assign mem_rdata_i = mem_rd_o ? dm[mem_addr_o] : ~dm[mem_addr_o];
  // high byte scrambled so a wrong page select shows up in the latch
  assign prog_data_i = prog_rd_o ? {prog_addr_o[15:8] ^ 8'hC3, prog_addr_o[7:0]} :
    ~{prog_addr_o[15:8] ^ 8'hC3, prog_addr_o[7:0]};
  always @(posedge clk_i) begin
    if (mem_we_o) dm[mem_addr_o] <= mem_wdata_o;
    if (mem_we_o) lw <= {mem_addr_o, mem_wdata_o};
  end
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wb(logic w, logic [4:0] a, logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
  endtask
  // commands written while busy are dropped, so poll until idle
  task automatic run(logic [3:0] op, logic [2:0] b, logic [7:0] a);
    wb(1, `EMX_REG_CMD, {16'h0000, a, 1'b0, b, op});
    do wb(0, `EMX_REG_STAT, 0); while (rd[0] !== 1'b0);
  endtask
  task automatic sk(logic e);
    chk("skip", {6'h00, e ? `EMX_CYC_SKIP : `EMX_CYC_NORM, e}, {rd[15:8], rd[1]});
  endtask
  task automatic t_swap;
    dm[16] = 8'h3C;
    dm[17] = 8'hA5;
    run(`EMX_OP_SWAP_MEM, 0, 16);
    chk("swap mem", 8'hC3, dm[16]);
    chk("swap flags", 0, rd[2:1]);
    run(`EMX_OP_SWAP_ACC, 0, 17);
    chk("swap src", 8'hA5, dm[17]);
    wb(0, `EMX_REG_ACC, 0);
    chk("swap acc", 8'h5A, rd);
  endtask
  task automatic t_skip;
    dm[1] = 0;
    dm[2] = 8'h80;
    dm[3] = 8'hF7;
    run(`EMX_OP_SZ_MEM, 0, 1);
    sk(1);
    lw = 0;
    run(`EMX_OP_SZ_MEM, 0, 2);
    sk(0);
    chk("sz wb", 16'h0280, lw);
    run(`EMX_OP_SZ_ACC, 0, 1);
    sk(1);
    run(`EMX_OP_SZ_ACC, 0, 2);
    sk(0);
    wb(0, `EMX_REG_ACC, 0);
    chk("sza acc", 8'h80, rd);
    run(`EMX_OP_SZ_BIT, 3, 3);
    sk(1);
    run(`EMX_OP_SZ_BIT, 0, 3);
    sk(0);
    wb(0, `EMX_REG_CMD, 0);
    chk("cmd", 32'h0000_0305, rd);
  endtask
  task automatic t_table;
    wb(1, `EMX_REG_ACC, 8'h66);
    wb(1, `EMX_REG_TPH, 8'h12);
    wb(1, `EMX_REG_TPL, 8'h34);
    run(`EMX_OP_TRD_PAGE, 0, 32);
    chk("trd lo", 8'h34, dm[32]);
    wb(0, `EMX_REG_TBH, 0);
    chk("trd hi", 8'hD1, rd);
    run(`EMX_OP_TRD_LAST, 0, 33);
    chk("last lo", 8'h34, dm[33]);
    wb(0, `EMX_REG_TBH, 0);
    chk("last hi", 8'h3C, rd);
    wb(1, `EMX_REG_TPL, 8'hFF);
    run(`EMX_OP_ITRD_PAGE, 0, 34);
    chk("inc lo", 0, dm[34]);
    wb(0, `EMX_REG_TBH, 0);
    chk("inc hi", 8'hD1, rd);
    run(`EMX_OP_ITRD_LAST, 0, 35);
    chk("incl lo", 1, dm[35]);
    wb(0, `EMX_REG_TBH, 0);
    chk("incl hi", 8'h3C, rd);
    wb(0, `EMX_REG_TPL, 0);
    chk("tpl inc", 1, rd);
    wb(0, `EMX_REG_ACC, 0);
    chk("trd acc", 8'h66, rd);
  endtask
  task automatic t_xor;
    dm[5] = 8'hF0;
    wb(1, `EMX_REG_ACC, 8'hF0);
    run(`EMX_OP_XOR_ACC, 0, 5);
    chk("xor z", 1, rd[2]);
    wb(0, `EMX_REG_ACC, 0);
    chk("xor acc", 0, rd);
    run(`EMX_OP_SWAP_MEM, 0, 5);
    chk("swap z", 1, rd[2]);
    wb(1, `EMX_REG_ACC, 8'hF0);
    run(`EMX_OP_XOR_MEM, 0, 5);
    chk("xorm mem", 8'hFF, dm[5]);
    chk("xorm z", 0, rd[2]);
    wb(0, 5'h18, 0);
    chk("unmapped", 0, rd);
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    t_swap;
    t_skip;
    t_table;
    t_xor;
    report_and_stop;
  end
  // whole run is a few hundred cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    failures++;
    report_and_stop;
  end
endmodule
`default_nettype wire
